//--- include/clsp_pkg.sv
package clsp_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_GAINS   = 8'h04;
	localparam logic [7:0] OFF_TGT     = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_POWER   = 8'h10;
	localparam logic [7:0] OFF_MEAS    = 8'h14;

	// Control field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_ENC_BIT   = 4;
	localparam int CTRL_RUN_BIT   = 5;
	localparam int CTRL_PANEL_BIT = 6;

	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] GAINS_RST = 32'h0000_0000;

	// Control period
	localparam int CLK_HZ         = 20_000_000;
	localparam int PERIOD_MS      = 16;
	localparam int PERIOD_CYCLES  = CLK_HZ / 1000 * PERIOD_MS;

	// Analog speed scaling: 8-bit ADC code, mid-scale reads zero
	localparam logic [7:0] ADC_MID = 8'h80;
	localparam logic signed [7:0] SPD_MAX = 8'sh7f;
	localparam logic signed [7:0] SPD_MIN = -8'sh7f;

	// Power command range
	localparam logic signed [15:0] PWR_MAX = 16'sh007f;
	localparam logic signed [15:0] PWR_MIN = -16'sh007f;

	typedef enum logic [1:0] {
		MC_OPEN,
		MC_SPD_SEP,
		MC_SPD_MIX,
		MC_SPD_A_POS_B
	} clsp_mode_type;

	typedef struct packed {
		logic [7:0] kp;
		logic [7:0] ki;
		logic [7:0] kd;
	} clsp_gains_type;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
	} clsp_adc_type;

endpackage

//--- rtl/clsp_speed_pid.sv
`timescale 1ns/1ps
// Operation
// (RULE1) Mode selects separate, mixed, or A-speed B-position
// (RULE2) A-speed B-position mode regulates channel A only
// (RULE3) Panel path cannot select closed loop modes
// (RULE4) Encoder feedback only when module fitted
// (RULE5) Sensor gives 0V reverse, 5V forward, 2.5V stop
// (RULE6) Analog reading maps to signed -127..+127
// (RULE7) Every 16 ms sample speed, error = target - speed
// (RULE8) Proportional term is error times gain
// (RULE9) Differential term is error change times gain
// (RULE10) Integral term accumulates error times gain
// (RULE11) Keep adjusting power each period until reached
// (RULE12) Lasting low feedback ramps power to full
// (RULE13) One gain set shared by both channels
// (RULE14) Saturate sum and integral to power range
module clsp_speed_pid #(
	parameter int PERIOD = clsp_pkg::PERIOD_CYCLES
) (
	// Clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Sensors
	input  wire clsp_pkg::clsp_adc_type adc_speed,
	input  wire logic signed [7:0]     enc_speed_a,
	input  wire logic signed [7:0]     enc_speed_b,
	input  wire logic                  enc_present,
	// Front panel mode request
	input  wire logic                  panel_mode_we,
	input  wire logic [1:0]            panel_mode,
	// Power stage
	output logic signed [7:0]          power_a,
	output logic signed [7:0]          power_b,
	output logic                       loop_active_a,
	output logic                       loop_active_b,
	output logic                       period_tick
);

	logic [31:0]          ctrl_q;
	clsp_pkg::clsp_gains_type gains_q;
	logic signed [7:0]    tgt_a_q;
	logic signed [7:0]    tgt_b_q;
	logic                 panel_refused_q;
	logic [31:0]          cnt_q;
	logic                 tick;
	clsp_pkg::clsp_adc_type adc_s1_q;
	clsp_pkg::clsp_adc_type adc_s2_q;
	logic [1:0]           encp_q;
	logic signed [7:0]    enca_s1_q, enca_s2_q, encb_s1_q, encb_s2_q;
	logic signed [7:0]    meas_q [2];
	logic signed [15:0]   pwr_q [2];
	logic [1:0]           act;

	clsp_pkg::clsp_mode_type mode;
	assign mode = clsp_pkg::clsp_mode_type'(ctrl_q[clsp_pkg::CTRL_MODE_LSB +: 2]);

	wire wr_en = psel && penable && pwrite;

	// Sensor pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_s1_q  <= '0;
			adc_s2_q  <= '0;
			encp_q    <= 2'h0;
			enca_s1_q <= 8'sh00;
			enca_s2_q <= 8'sh00;
			encb_s1_q <= 8'sh00;
			encb_s2_q <= 8'sh00;
		end else begin
			adc_s1_q  <= adc_speed;
			adc_s2_q  <= adc_s1_q;
			encp_q    <= {encp_q[0], enc_present};
			enca_s1_q <= enc_speed_a;
			enca_s2_q <= enca_s1_q;
			encb_s1_q <= enc_speed_b;
			encb_s2_q <= encb_s1_q;
		end
	end

	// Control and gain registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q          <= clsp_pkg::CTRL_RST;
			gains_q         <= clsp_pkg::GAINS_RST[23:0];
			tgt_a_q         <= 8'sh00;
			tgt_b_q         <= 8'sh00;
			panel_refused_q <= 1'b0;
		end else begin
			if (wr_en && paddr == clsp_pkg::OFF_CTRL) begin
				ctrl_q <= {26'h0, pwdata[5:0]};
			end else if (panel_mode_we
				&& clsp_pkg::clsp_mode_type'(panel_mode) == clsp_pkg::MC_OPEN) begin
				ctrl_q[clsp_pkg::CTRL_MODE_LSB +: 2] <= panel_mode;
			end
			// Refusal is recorded even beside a bus write; it wins over a clear
			if (panel_mode_we
				&& clsp_pkg::clsp_mode_type'(panel_mode) != clsp_pkg::MC_OPEN) begin
				panel_refused_q <= 1'b1; // see (RULE3)
			end else if (wr_en && paddr == clsp_pkg::OFF_STATUS
				&& pwdata[clsp_pkg::CTRL_PANEL_BIT]) begin
				panel_refused_q <= 1'b0;
			end
			if (wr_en && paddr == clsp_pkg::OFF_GAINS) begin
				gains_q <= pwdata[23:0]; // see (RULE13)
			end
			if (wr_en && paddr == clsp_pkg::OFF_TGT) begin
				tgt_a_q <= pwdata[7:0];
				tgt_b_q <= pwdata[15:8];
			end
		end
	end

	// 16 ms control period divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
		end else if (cnt_q == 32'(PERIOD - 1)) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end
	assign tick = (cnt_q == 32'(PERIOD - 1)); // see (RULE7)

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_tick <= 1'b0;
		end else begin
			period_tick <= tick;
		end
	end

	// Channel enables by mode
	always_comb begin
		act = 2'b00;
		if (ctrl_q[clsp_pkg::CTRL_RUN_BIT]) begin
			case (mode)
				clsp_pkg::MC_SPD_SEP:     act = 2'b11; // see (RULE1)
				clsp_pkg::MC_SPD_MIX:     act = 2'b11; // see (RULE1)
				clsp_pkg::MC_SPD_A_POS_B: act = 2'b01; // see (RULE2)
				default:                  act = 2'b00;
			endcase
		end
	end

	// Per-channel PID
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [7:0]         adc;
		logic signed [7:0]  enc;
		logic signed [7:0]  tgt;
		logic signed [8:0]  ana;
		logic signed [7:0]  meas;
		logic signed [15:0] err;
		logic signed [15:0] err_prev_q;
		logic signed [15:0] integ_q;
		logic signed [31:0] p_term, d_term, i_sum, i_sat, total;
		logic signed [15:0] i_new;

		assign adc = (ch == 0) ? adc_s2_q.a : adc_s2_q.b;
		assign enc = (ch == 0) ? enca_s2_q : encb_s2_q;
		assign tgt = (ch == 0) ? tgt_a_q : tgt_b_q;

		// Analog code to signed speed, clamped to +/-127
		assign ana = $signed({1'b0, adc}) - $signed({1'b0, clsp_pkg::ADC_MID}); // see (RULE6)
		assign meas = (ana < -9'sd127) ? clsp_pkg::SPD_MIN : ana[7:0]; // see (RULE6)

		always_comb begin
			p_term = 32'sh0;
			d_term = 32'sh0;
			i_sum  = 32'sh0;
			i_sat  = 32'sh0;
			total  = 32'sh0;
			i_new  = 16'sh0;
			p_term = err * $signed({1'b0, gains_q.kp}); // see (RULE8)
			d_term = (err - err_prev_q) * $signed({1'b0, gains_q.kd}); // see (RULE9)
			i_sum  = 32'(integ_q) + err * $signed({1'b0, gains_q.ki}); // see (RULE10)
			if (i_sum > 32'(clsp_pkg::PWR_MAX)) begin
				i_sat = 32'(clsp_pkg::PWR_MAX); // see (RULE14)
			end else if (i_sum < 32'(clsp_pkg::PWR_MIN)) begin
				i_sat = 32'(clsp_pkg::PWR_MIN); // see (RULE14)
			end else begin
				i_sat = i_sum;
			end
			i_new = i_sat[15:0];
			total = p_term + d_term + i_sat; // see (RULE11)
		end

		// Feedback source: encoder only with module fitted
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meas_q[ch] <= 8'sh00;
			end else if (tick) begin
				if (ctrl_q[clsp_pkg::CTRL_ENC_BIT] && encp_q[1]) begin
					meas_q[ch] <= enc; // see (RULE4)
				end else begin
					meas_q[ch] <= meas; // see (RULE4)
				end
			end
		end

		assign err = 16'(tgt) - 16'(meas_q[ch]); // see (RULE7)

		// Update once per period, one cycle after sampling
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				err_prev_q <= 16'sh0;
				integ_q    <= 16'sh0;
				pwr_q[ch]  <= 16'sh0;
			end else if (!act[ch]) begin
				err_prev_q <= 16'sh0;
				integ_q    <= 16'sh0;
				pwr_q[ch]  <= 16'sh0;
			end else if (period_tick) begin
				err_prev_q <= err; // see (RULE9)
				integ_q    <= i_new; // see (RULE12)
				if (total > 32'(clsp_pkg::PWR_MAX)) begin
					pwr_q[ch] <= clsp_pkg::PWR_MAX; // see (RULE14)
				end else if (total < 32'(clsp_pkg::PWR_MIN)) begin
					pwr_q[ch] <= clsp_pkg::PWR_MIN; // see (RULE14)
				end else begin
					pwr_q[ch] <= total[15:0];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_a       <= 8'sh00;
			power_b       <= 8'sh00;
			loop_active_a <= 1'b0;
			loop_active_b <= 1'b0;
		end else begin
			power_a       <= pwr_q[0][7:0];
			power_b       <= pwr_q[1][7:0];
			loop_active_a <= act[0];
			loop_active_b <= act[1];
		end
	end

	// APB read and answer, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					clsp_pkg::OFF_CTRL:   prdata <= ctrl_q;
					clsp_pkg::OFF_GAINS:  prdata <= {8'h0, gains_q};
					clsp_pkg::OFF_TGT:    prdata <= {16'h0, tgt_b_q, tgt_a_q};
					clsp_pkg::OFF_STATUS: prdata <= {25'h0, panel_refused_q,
						encp_q[1], 3'h0, act};
					clsp_pkg::OFF_POWER:  prdata <= {16'h0, pwr_q[1][7:0], pwr_q[0][7:0]};
					clsp_pkg::OFF_MEAS:   prdata <= {16'h0, meas_q[1], meas_q[0]};
					default: begin
						prdata  <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

endmodule

//--- tb/clsp_sensor_model.sv
`timescale 1ns/1ps
module clsp_sensor_model (
	// Shaft speeds
	input  wire logic signed [7:0] tach_a,
	input  wire logic signed [7:0] tach_b,
	input  wire logic signed [7:0] enc_in_a,
	input  wire logic signed [7:0] enc_in_b,
	input  wire logic              fitted,
	// Sensor pins
	output clsp_pkg::clsp_adc_type adc,
	output logic signed [7:0]      enc_a,
	output logic signed [7:0]      enc_b,
	output logic                   enc_on
);
	assign adc.a = tach_a + 8'h80;
	assign adc.b = tach_b + 8'h80;
	// Unfitted module drives inverted encoder speeds
	assign enc_a = fitted ? enc_in_a : ~enc_in_a;
	assign enc_b = fitted ? enc_in_b : ~enc_in_b;
	assign enc_on = fitted;
endmodule

//--- tb/clsp_speed_pid_chk.sv
`timescale 1ns/1ps
module clsp_speed_pid_chk #(
	parameter int PERIOD = 20
) (
	// Bus
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	// Loop
	input wire logic signed [7:0] power_a,
	input wire logic signed [7:0] power_b,
	input wire logic              loop_active_a,
	input wire logic              loop_active_b,
	input wire logic              period_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] gap_q;
	logic        seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end else begin
			gap_q <= period_tick ? 32'h0 : gap_q + 32'h1;
			seen_q <= seen_q | period_tick;
		end
	end
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	a_tick_pulse: assert property (period_tick |=> !period_tick)
		else $error("tick held");
	a_tick_gap: assert property (period_tick && seen_q |-> gap_q == PERIOD - 1)
		else $error("tick spacing");
	a_power_range: assert property (power_a != 8'h80 && power_b != 8'h80)
		else $error("power range");
	a_power_at_tick: assert property (loop_active_a && $past(loop_active_a)
		&& $changed(power_a) |-> $past(period_tick, 2)) else $error("power off tick");
	a_idle_zero: assert property (!loop_active_b [*3] |-> power_b == 8'h00)
		else $error("idle power");
	cover property (pslverr);
	cover property (period_tick && loop_active_a && !loop_active_b);
	cover property (power_a == 8'h7f);
endmodule
bind clsp_speed_pid clsp_speed_pid_chk #(.PERIOD(PERIOD)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.power_a(power_a), .power_b(power_b), .loop_active_a(loop_active_a),
	.loop_active_b(loop_active_b), .period_tick(period_tick));

//--- tb/clsp_speed_pid_tb.sv
`timescale 1ns/1ps
module clsp_speed_pid_tb;
	logic                   pclk, presetn, psel, penable, pwrite, we, fit, pready, pslverr;
	logic                   la, lb, tick, enc_on;
	logic [7:0]             paddr;
	logic [1:0]             panel_mode;
	logic [31:0]            pwdata, prdata;
	logic signed [7:0]      tach_a, tach_b, esp_a, esp_b, enc_a, enc_b, power_a, power_b;
	clsp_pkg::clsp_adc_type adc;
	int                     n_fail, total_checks;
	clsp_sensor_model sen (.tach_a(tach_a), .tach_b(tach_b), .enc_in_a(esp_a),
		.enc_in_b(esp_b), .fitted(fit), .adc(adc), .enc_a(enc_a), .enc_b(enc_b), .enc_on(enc_on));
	clsp_speed_pid #(.PERIOD(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .adc_speed(adc), .enc_speed_a(enc_a),
		.enc_speed_b(enc_b), .enc_present(enc_on), .panel_mode_we(we),
		.panel_mode(panel_mode), .power_a(power_a), .power_b(power_b),
		.loop_active_a(la), .loop_active_b(lb), .period_tick(tick));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task complete_run;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, ex});
	endtask
	task rst;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task tick_wait;
		do @(posedge pclk); while (tick !== 1'b1);
		// Power output follows the loop update by one edge
		@(posedge pclk);
		@(negedge pclk);
	endtask
	task t_regs;
		rd(clsp_pkg::OFF_CTRL, clsp_pkg::CTRL_RST, 1'b0);
		rd(clsp_pkg::OFF_GAINS, clsp_pkg::GAINS_RST, 1'b0);
		rd(8'h18, 32'h0, 1'b1);
	endtask
	task t_panel;
		for (int m = 1; m < 4; m++) begin
			@(posedge pclk);
			we <= 1'b1;
			panel_mode <= 2'(m);
			@(posedge pclk);
			we <= 1'b0;
			rd(clsp_pkg::OFF_CTRL, 32'h0, 1'b0);
			rd(clsp_pkg::OFF_STATUS, 32'h40, 1'b0);
			wr(clsp_pkg::OFF_STATUS, 32'h40);
			rd(clsp_pkg::OFF_STATUS, 32'h0, 1'b0);
		end
	endtask
	task t_split;
		rst;
		tach_a <= 8'sh04;
		wr(clsp_pkg::OFF_GAINS, 32'h0001_0000);
		wr(clsp_pkg::OFF_TGT, 32'h0000_050a);
		wr(clsp_pkg::OFF_CTRL, 32'h0000_0023);
		tick_wait;
		chk(power_a, 8'sh06);
		chk(power_b, 8'sh00);
		chk({la, lb}, 2'b10);
		rd(clsp_pkg::OFF_TGT, 32'h0000_050a, 1'b0);
		rd(clsp_pkg::OFF_POWER, 32'h0000_0006, 1'b0);
		rd(clsp_pkg::OFF_MEAS, 32'h0000_0004, 1'b0);
	endtask
	task t_ramp;
		logic signed [7:0] ea;
		rst;
		tach_a <= 8'sh00;
		wr(clsp_pkg::OFF_GAINS, 32'h0000_0100);
		wr(clsp_pkg::OFF_TGT, 32'h0000_fb14);
		wr(clsp_pkg::OFF_CTRL, 32'h0000_0021);
		for (int k = 1; k < 9; k++) begin
			tick_wait;
			ea = (k * 20 > 127) ? 8'sh7f : 8'(k * 20);
			chk(power_a, ea);
			chk(power_b, 8'(-5 * k));
		end
	endtask
	task t_diff;
		rst;
		fit <= 1'b1;
		esp_a <= 8'sh03;
		tach_a <= 8'sh32;
		tach_b <= 8'sh80;
		wr(clsp_pkg::OFF_GAINS, 32'h0000_0002);
		wr(clsp_pkg::OFF_TGT, 32'h0000_000a);
		wr(clsp_pkg::OFF_CTRL, 32'h0000_0032);
		tick_wait;
		chk(power_a, 8'sh0e);
		rd(clsp_pkg::OFF_STATUS, 32'h23, 1'b0);
		tick_wait;
		chk(power_a, 8'sh00);
		@(posedge pclk);
		fit <= 1'b0;
		tick_wait;
		chk(power_a, 8'sha2);
		chk(power_b, 8'sh7f);
		rd(clsp_pkg::OFF_MEAS, 32'h0000_8132, 1'b0);
	endtask
	initial begin
		{presetn, psel, penable, pwrite, we, fit, paddr, pwdata, panel_mode} = '0;
		{tach_a, tach_b, esp_a, esp_b} = '0;
		n_fail = 0;
		total_checks = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_panel;
		t_split;
		t_ramp;
		t_diff;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		complete_run;
	end
endmodule
